/* hdl/ljatx_pkg.sv */
package ljatx_pkg;

   localparam int DATA_W        = 32;
   localparam int PTR_W         = 7;
   localparam int CNT_W         = 8;
   localparam int GAP_W         = 10;
   localparam int LOSS_W        = 9;
   localparam int CTRL_W        = 4;

   // Clock rates in Hz
   localparam int REF_HZ        = 250_000_000;
   localparam int E1_HZ         = 2_048_000;
   localparam int T1_HZ         = 1_544_000;
   localparam int E1_BIT_CYC    = REF_HZ / E1_HZ;
   localparam int T1_BIT_CYC    = REF_HZ / T1_HZ;
   localparam int PHASE_STEPS   = 8;
   localparam int NEAR_LIMIT    = 2;

   localparam int SHALLOW_DEPTH = 32;
   localparam int DEEP_DEPTH    = 64;

   // Corner frequencies in tenths of Hz
   localparam int E1_CORNER_DHZ = 35;
   localparam int T1_CORNER_DHZ = 60;
   localparam int GAP_DIV       = 1024;
   localparam int PIN_GAP_E1    = E1_HZ * 10 / (E1_CORNER_DHZ * GAP_DIV);
   localparam int PIN_GAP_T1    = T1_HZ * 10 / (T1_CORNER_DHZ * GAP_DIV);
   localparam int HOST_SHIFT_HI = 1;
   localparam int HOST_SHIFT_LO = 3;

   // Transmit clock loss timeout
   localparam int LOSS_NS       = 2000;
   localparam int LOSS_CYC      = LOSS_NS * (REF_HZ / 1_000_000) / 1000;

   localparam logic [DATA_W-1:0] ADDR_CTRL   = 32'h0000_0000;
   localparam logic [DATA_W-1:0] ADDR_STATUS = 32'h0000_0004;

   typedef struct packed {
      logic e1;
      logic corner;
      logic deep;
      logic path_tx;
   } ljatx_ctrl_s;

   localparam ljatx_ctrl_s CTRL_RST = 4'h3;

   typedef enum logic [1:0] {ST_IDLE, ST_PRIME, ST_RUN} ljatx_run_e;

   typedef struct packed {
      logic                        rs1;
      logic                        rs2;
      logic                        tog;
      logic [PTR_W-1:0]            wbin;
      logic [PTR_W-1:0]            wgray;
      logic [DEEP_DEPTH-1:0][1:0]  mem;
   } ljatx_link_s;

   typedef struct packed {
      logic [2:0]        sy1;
      logic [2:0]        sy2;
      logic [PTR_W-1:0]  wg1;
      logic [PTR_W-1:0]  wg2;
      logic              tg1;
      logic              tg2;
      logic              tg3;
      logic [LOSS_W-1:0] loss;
      logic              clk_ok;
      ljatx_run_e        st;
      logic [PTR_W-1:0]  rptr;
      logic [CNT_W-1:0]  ph;
      logic [GAP_W-1:0]  gap;
      logic              deep_q;
      logic              tx_q;
      ljatx_ctrl_s       ctrl;
      logic              wr_pend;
      logic [DATA_W-1:0] waddr;
      logic [DATA_W-1:0] hrdata;
      logic              hready;
      logic              hresp;
      logic              out_clk;
      logic              pos;
      logic              neg;
      logic              oe;
   } ljatx_ref_s;

   function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
      logic [PTR_W-1:0] b;
      b = g;
      for (int i = PTR_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

endpackage

/* hdl/ljatx_top.sv */
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
// Operation
// (R1) Data is written with its own input clock and read with the smoothed clock.
// (R2) Within two entries of overflow or underflow the read clock moves 1/8 bit.
// (R3) Latency through the path is 16 bits shallow and 32 bits deep.
// (R4) In host mode a control bit puts the smoother in the rx or tx path.
// (R5) In host mode a control bit picks a 32 or 64 entry two-bit FIFO.
// (R6) In host mode depth and a corner bit together set the corner frequency.
// (R7) In strapped mode a pin puts the smoother in the rx or tx path.
// (R8) In strapped mode the depth is always 64.
// (R9) In strapped mode the corner is 3.5 Hz for E1 and 6 Hz for T1.
// (R10) Without a transmit clock both line outputs are off and undriven.
// (R11) Positive marks leave on the positive output, negative on the negative.
// (R12) With all transmit inputs idle the outputs may stay at their last state.
// (R13) The framer should hold exactly one transmit input low while idle.
// (R14) Or the framer may run the reference clock at 10 kHz to 10 MHz.
// (R15) Or it may run the transmit clock or toggle data at 100 kHz to 10 MHz.
// (R16) After reset or a depth change reading starts half the depth behind.
module ljatx_top (
   // System clock and reset
   input  wire logic                          I_REF_CLK,
   input  wire logic                          I_RST,
   // AHB-Lite slave
   input  wire logic                          I_HSEL,
   input  wire logic [ljatx_pkg::DATA_W-1:0]  I_HADDR,
   input  wire logic [1:0]                    I_HTRANS,
   input  wire logic                          I_HWRITE,
   input  wire logic [2:0]                    I_HSIZE,
   input  wire logic [ljatx_pkg::DATA_W-1:0]  I_HWDATA,
   input  wire logic                          I_HREADY,
   output logic      [ljatx_pkg::DATA_W-1:0]  O_HRDATA,
   output logic                               O_HREADYOUT,
   output logic                               O_HRESP,
   // Framer link
   input  wire logic                          I_TX_CLOCK_IN,
   input  wire logic                          I_TX_POS_DATA,
   input  wire logic                          I_TX_NEG_DATA,
   // Straps
   input  wire logic                          I_HOST_MODE,
   input  wire logic                          I_ATTEN_PATH_SELECT,
   input  wire logic                          I_E1_MODE,
   // Line side
   output logic                               O_TX_ATTEN_OUT_CLOCK,
   output logic                               O_LINE_OUT_POS,
   output logic                               O_LINE_OUT_NEG,
   output logic                               O_LINE_OUT_POS_OE,
   output logic                               O_LINE_OUT_NEG_OE
);
   import ljatx_pkg::*;

   ljatx_link_s       lk_q;
   ljatx_link_s       lk_d;
   ljatx_ref_s        q;
   ljatx_ref_s        d;

   logic              host;
   logic              tx;
   logic              deep;
   logic              e1;
   logic [PTR_W-1:0]  depth;
   logic [PTR_W-1:0]  wbin;
   logic [PTR_W-1:0]  fill;
   logic [CNT_W-1:0]  bitc;
   logic [CNT_W-1:0]  eighth;
   logic [CNT_W-1:0]  lim;
   logic              over;
   logic              under;
   logic              adj;
   logic              bit_end;
   logic              rd_ev;
   logic [GAP_W-1:0]  gap_new;
   logic [1:0]        entry;

   function automatic logic [GAP_W-1:0] gap_bits(input logic h, input logic dp,
                                                 input logic cn, input logic e);
      int base;
      base = dp ? DEEP_DEPTH : SHALLOW_DEPTH;
      if (!h) begin
         return e ? GAP_W'(PIN_GAP_E1) : GAP_W'(PIN_GAP_T1);
      end
      return GAP_W'(base << (cn ? HOST_SHIFT_LO : HOST_SHIFT_HI));
   endfunction

   // ---- Link side, written on the falling edge of the framer clock ----
   always_comb begin
      lk_d     = lk_q;
      lk_d.rs1 = I_RST;
      lk_d.rs2 = lk_q.rs1;
      lk_d.tog = ~lk_q.tog;
      if (lk_q.rs2) begin
         // Toggle must leave reset known or presence never resolves
         lk_d.tog   = 1'b0;
         lk_d.wbin  = '0;
         lk_d.wgray = '0;
      end else begin
         // R1 write with input clock
         lk_d.mem[lk_q.wbin[5:0]] = {I_TX_NEG_DATA, I_TX_POS_DATA};
         lk_d.wbin  = lk_q.wbin + PTR_W'(1);
         lk_d.wgray = bin2gray(lk_q.wbin + PTR_W'(1));
      end
   end

   always_ff @(negedge I_TX_CLOCK_IN) begin
      lk_q <= lk_d;
   end

   // ---- Reference side ----
   // Host mode strap; R7 strap path select is on the tx line below
   assign host    = q.sy2[2];
   // R4 register path select
   assign tx      = host ? q.ctrl.path_tx : q.sy2[1];
   // R5 depth choice, R8 fixed deep
   assign deep    = host ? q.ctrl.deep : 1'b1;
   assign e1      = host ? q.ctrl.e1 : q.sy2[0];
   assign depth   = deep ? PTR_W'(DEEP_DEPTH) : PTR_W'(SHALLOW_DEPTH);
   assign wbin    = gray2bin(q.wg2);
   assign fill    = wbin - q.rptr;
   assign bitc    = e1 ? CNT_W'(E1_BIT_CYC) : CNT_W'(T1_BIT_CYC);
   assign eighth  = bitc / CNT_W'(PHASE_STEPS);
   // R2 near-limit detection
   assign over    = fill >= depth - PTR_W'(NEAR_LIMIT);
   assign under   = fill <= PTR_W'(NEAR_LIMIT);
   assign adj     = (over || under) && q.gap == '0;
   // R2 shift by one eighth bit
   assign lim     = !adj ? bitc : over ? bitc - eighth : bitc + eighth;
   assign bit_end = q.st == ST_RUN && (tx ? q.ph >= lim - CNT_W'(1) : 1'b1);
   assign rd_ev   = bit_end && fill != '0;
   // R6 corner from depth and bit, R9 strapped corner
   assign gap_new = gap_bits(host, deep, q.ctrl.corner, e1);
   assign entry   = lk_q.mem[q.rptr[5:0]];

   always_comb begin
      logic [DATA_W-1:0] rdv;
      rdv = '0;
      d   = q;

      // Pin and pointer synchronisers
      d.sy1 = {I_HOST_MODE, I_ATTEN_PATH_SELECT, I_E1_MODE};
      d.sy2 = q.sy1;
      d.wg1 = lk_q.wgray;
      d.wg2 = q.wg1;
      d.tg1 = lk_q.tog;
      d.tg2 = q.tg1;
      d.tg3 = q.tg2;

      // R10 transmit clock presence
      if (q.tg2 != q.tg3) begin
         d.loss   = '0;
         d.clk_ok = 1'b1;
      end else if (q.loss == LOSS_W'(LOSS_CYC - 1)) begin
         d.clk_ok = 1'b0;
      end else begin
         d.loss = q.loss + LOSS_W'(1);
      end

      case (q.st)
         ST_IDLE: begin
            d.rptr = wbin;
            if (q.clk_ok) begin
               d.st = ST_PRIME;
            end
         end
         // R16 wait for half depth, R3 fixed latency
         ST_PRIME: begin
            if (!tx || fill >= (depth >> 1)) begin
               d.st = ST_RUN;
               d.ph = '0;
            end
         end
         ST_RUN: begin
            d.ph = q.ph + CNT_W'(1);
            if (bit_end) begin
               d.ph = '0;
               // R1 read with smoothed clock, R11 mark polarity
               d.pos = rd_ev && entry[0];
               d.neg = rd_ev && entry[1];
               if (rd_ev) begin
                  d.rptr = q.rptr + PTR_W'(1);
               end
               if (adj) begin
                  d.gap = gap_new;
               end else if (q.gap != '0) begin
                  d.gap = q.gap - GAP_W'(1);
               end
            end
         end
         default: d.st = ST_IDLE;
      endcase

      // Bypass forwards each bit as a one-cycle clock pulse
      d.out_clk = q.st == ST_RUN && (tx ? q.ph < (lim >> 1) : rd_ev);

      // R16 restart on depth or path change; also recovers from overrun
      if (!q.clk_ok || q.deep_q != deep || q.tx_q != tx || fill > depth) begin
         d.st      = q.clk_ok ? ST_PRIME : ST_IDLE;
         d.rptr    = wbin;
         d.out_clk = 1'b0;
      end
      d.deep_q = deep;
      d.tx_q   = tx;

      // R10 outputs off without clock; R12 otherwise hold last level
      d.oe = q.clk_ok;
      if (!q.clk_ok) begin
         d.pos = 1'b0;
         d.neg = 1'b0;
      end

      // AHB-Lite: zero wait states, always OKAY
      if (I_HADDR == ADDR_CTRL) begin
         rdv = DATA_W'(q.ctrl);
      end else if (I_HADDR == ADDR_STATUS) begin
         rdv = {17'h0, fill, 5'h0, host, q.st == ST_RUN, q.clk_ok};
      end else begin
         rdv = '0;
      end
      d.hready  = 1'b1;
      d.hresp   = 1'b0;
      d.wr_pend = I_HSEL && I_HTRANS[1] && I_HREADY && I_HWRITE;
      if (I_HSEL && I_HTRANS[1] && I_HREADY) begin
         d.waddr = I_HADDR;
         if (!I_HWRITE) begin
            d.hrdata = rdv;
         end
      end
      if (q.wr_pend && q.waddr == ADDR_CTRL) begin
         d.ctrl = ljatx_ctrl_s'(I_HWDATA[CTRL_W-1:0]);
      end

      if (I_RST) begin
         d        = '0;
         d.ctrl   = CTRL_RST;
         d.hready = 1'b1;
         d.st     = ST_IDLE;
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      q <= d;
   end

   assign O_HRDATA             = q.hrdata;
   assign O_HREADYOUT          = q.hready;
   assign O_HRESP              = q.hresp;
   assign O_TX_ATTEN_OUT_CLOCK = q.out_clk;
   assign O_LINE_OUT_POS       = q.pos;
   assign O_LINE_OUT_NEG       = q.neg;
   assign O_LINE_OUT_POS_OE    = q.oe;
   assign O_LINE_OUT_NEG_OE    = q.oe;

   // ---- Assertions ----
   property p_wr_ptr;
      @(negedge I_TX_CLOCK_IN) disable iff (lk_q.rs2)
      !lk_d.rs2 |=> lk_q.wbin == $past(lk_q.wbin) + PTR_W'(1);
   endproperty
   a_wr_ptr: assert property (p_wr_ptr) else $error("write ptr stuck"); // R1

   property p_fast;
      @(posedge I_REF_CLK) disable iff (I_RST)
      (q.st == ST_RUN && tx && over && q.gap == '0 && q.ph == '0 && q.clk_ok
       && q.deep_q == deep && q.tx_q == tx && fill <= depth)
      |-> lim == bitc - bitc / CNT_W'(8);
   endproperty
   a_fast: assert property (p_fast) else $error("no fast nudge"); // R2

   property p_prime;
      @(posedge I_REF_CLK) disable iff (I_RST)
      (q.st == ST_PRIME && tx && q.clk_ok && fill < (depth >> 1))
      |=> q.st != ST_RUN;
   endproperty
   a_prime: assert property (p_prime) else $error("early start"); // R16

   property p_latency;
      @(posedge I_REF_CLK) disable iff (I_RST)
      $rose(q.st == ST_RUN) && tx |-> $past(fill) >= (depth >> 1);
   endproperty
   a_latency: assert property (p_latency) else $error("bad latency"); // R3

   property p_pin_deep;
      @(posedge I_REF_CLK) disable iff (I_RST)
      !host |-> depth == PTR_W'(64) && gap_new != '0;
   endproperty
   a_pin_deep: assert property (p_pin_deep) else $error("strap depth"); // R8

   property p_gap;
      @(posedge I_REF_CLK) disable iff (I_RST)
      (bit_end && adj && tx && q.clk_ok && q.deep_q == deep
       && q.tx_q == tx && fill <= depth) |=> q.gap == $past(gap_new);
   endproperty
   a_gap: assert property (p_gap) else $error("corner gap"); // R6

   property p_loss;
      @(posedge I_REF_CLK) disable iff (I_RST)
      (q.loss == LOSS_W'(LOSS_CYC - 1) && q.tg2 == q.tg3)
      |=> !q.clk_ok ##1 (!O_LINE_OUT_POS_OE && !O_LINE_OUT_NEG_OE);
   endproperty
   a_loss: assert property (p_loss) else $error("outputs not off"); // R10

   property p_quiet;
      @(posedge I_REF_CLK) disable iff (I_RST)
      !q.clk_ok |=> !O_LINE_OUT_POS && !O_LINE_OUT_NEG;
   endproperty
   a_quiet: assert property (p_quiet) else $error("line driven"); // R10

   property p_mark;
      @(posedge I_REF_CLK) disable iff (I_RST)
      (rd_ev && q.clk_ok && q.deep_q == deep && q.tx_q == tx && fill <= depth)
      |=> O_LINE_OUT_POS == $past(entry[0]) && O_LINE_OUT_NEG == $past(entry[1]);
   endproperty
   a_mark: assert property (p_mark) else $error("mark polarity"); // R11

   c_run: cover property (@(posedge I_REF_CLK) $rose(q.st == ST_RUN));
   c_fast: cover property (@(posedge I_REF_CLK) bit_end && adj && over);
   c_slow: cover property (@(posedge I_REF_CLK) bit_end && adj && under);
   c_loss: cover property (@(posedge I_REF_CLK) $fell(q.clk_ok));

endmodule

/* tb/ljatx_framer.sv */
`timescale 1ns/100ps
module ljatx_framer (
   // Control from the bench
   input  wire logic       i_en,
   input  wire logic [7:0] i_div,
   input  wire logic [1:0] i_mark,
   // Link towards the device
   output logic            o_clk,
   output logic            o_pos,
   output logic            o_neg
);
   logic       base_clk;
   logic [7:0] cnt_q;

   initial begin
      base_clk = 1'b0;
      // Offset keeps link edges off the reference edges
      #1.3;
      forever #6 base_clk = ~base_clk;
   end

   initial begin
      cnt_q = 8'h00;
      o_clk = 1'b0;
      o_pos = 1'b0;
      o_neg = 1'b0;
   end

   always @(posedge base_clk) begin
      if (!i_en) begin
         cnt_q <= 8'h00;
         o_clk <= 1'b0;
      end else begin
         cnt_q <= (cnt_q + 8'h01 >= i_div) ? 8'h00 : cnt_q + 8'h01;
         if (cnt_q == 8'h00) begin
            o_clk <= 1'b1;
            o_pos <= i_mark[0];
            o_neg <= i_mark[1];
         end else if (cnt_q == (i_div >> 1)) begin
            o_clk <= 1'b0;
         end
      end
   end
endmodule

/* tb/line_jitter_attenuator_tx_out_tb.sv */
`timescale 1ns/100ps
module line_jitter_attenuator_tx_out_tb;
   import ljatx_pkg::*;
   logic        clk;
   logic        rst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        host_mode;
   logic        path_sel;
   logic        e1_mode;
   logic        out_clk;
   logic        o_pos;
   logic        o_neg;
   logic        o_poe;
   logic        o_noe;
   logic        tx_clk;
   logic        tx_pos;
   logic        tx_neg;
   logic        f_en;
   logic [7:0]  f_div;
   logic [1:0]  f_mark;
   logic [31:0] rng;
   logic [31:0] rd;
   int          error_cnt;
   int          n_compared;
   int          nfall;
   int          n;

   ljatx_top ljatx_top_i (
      .I_REF_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
      .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
      .O_HREADYOUT(hready), .O_HRESP(hresp), .I_TX_CLOCK_IN(tx_clk),
      .I_TX_POS_DATA(tx_pos), .I_TX_NEG_DATA(tx_neg),
      .I_HOST_MODE(host_mode), .I_ATTEN_PATH_SELECT(path_sel),
      .I_E1_MODE(e1_mode), .O_TX_ATTEN_OUT_CLOCK(out_clk),
      .O_LINE_OUT_POS(o_pos), .O_LINE_OUT_NEG(o_neg),
      .O_LINE_OUT_POS_OE(o_poe), .O_LINE_OUT_NEG_OE(o_noe));

   ljatx_framer ljatx_framer_i (
      .i_en(f_en), .i_div(f_div), .i_mark(f_mark),
      .o_clk(tx_clk), .o_pos(tx_pos), .o_neg(tx_neg));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(negedge tx_clk) nfall <= nfall + 1;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic int exp_lat(input logic host, input logic deep);
      return (!host || deep) ? DEEP_DEPTH / 2 : SHALLOW_DEPTH / 2;
   endfunction

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // One single transfer; answer taken at the data-phase edge
   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int k;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      @(posedge clk);
      for (k = 0; k < 100 && hready !== 1'b1; k++) @(posedge clk);
      if (k == 100) error_cnt++;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      for (k = 0; k < 100 && hready !== 1'b1; k++) @(posedge clk);
      if (k == 100) error_cnt++;
      q = hrdata;
      cmp_word({31'h0, hresp}, 32'h0);
   endtask

   task automatic run_path(input logic host, input logic deep);
      int k;
      int n0;
      int lat;
      f_mark <= 2'h1;
      f_en <= 1'b1;
      for (k = 0; k < 40000 && !(o_pos === 1'b1 && o_poe === 1'b1); k++)
         @(posedge clk);
      if (k == 40000) error_cnt++;
      n0 = nfall;
      for (k = 0; k < 40000 && nfall < n0 + 40; k++) @(posedge clk);
      if (k == 40000) error_cnt++;
      bus(1'b0, ADDR_STATUS, 32'h0, rd);
      cmp_word(rd & 32'h3, 32'h3);
      f_mark <= 2'h2;
      n0 = nfall;
      for (k = 0; k < 40000 && o_neg !== 1'b1; k++) @(posedge clk);
      if (k == 40000) error_cnt++;
      lat = nfall - n0;
      // fixed delay, small slack for the edge race
      cmp_word((lat >= exp_lat(host, deep) - 3 &&
                lat <= exp_lat(host, deep) + 3) ? 32'h1 : 32'h0, 32'h1);
      cmp_word({30'h0, o_neg, o_pos}, 32'h2);
      cmp_word({30'h0, o_noe, o_poe}, 32'h3);
   endtask

   initial begin
      #400000;
      error_cnt++;
      wrap_up();
   end

   initial begin
      rng = 32'h713d5378;
      error_cnt = 0;
      n_compared = 0;
      nfall = 0;
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      host_mode = 1'b1;
      path_sel = 1'b1;
      e1_mode = 1'b1;
      f_en = 1'b1;
      f_div = 8'd41;
      f_mark = 2'h1;
      repeat (6) @(posedge clk);
      // Link side resets only on its own edges
      for (n = 0; n < 2000 && nfall < 4; n++) @(posedge clk);
      f_en <= 1'b0;
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, ADDR_CTRL, 32'h0, rd);
      cmp_word(rd, {28'h0, CTRL_RST});
      rng = xs(rng);
      bus(1'b1, 32'h0000_0040, rng, rd);
      bus(1'b0, 32'h0000_0040, 32'h0, rd);
      cmp_word(rd, 32'h0);
      bus(1'b0, ADDR_CTRL, 32'h0, rd);
      cmp_word(rd, {28'h0, CTRL_RST});
      repeat (600) @(posedge clk);
      bus(1'b0, ADDR_STATUS, 32'h0, rd);
      cmp_word(rd & 32'h1, 32'h0);
      cmp_word({30'h0, o_noe, o_poe}, 32'h0);
      rng = xs(rng);
      bus(1'b1, ADDR_CTRL, {rng[31:4], 4'hb}, rd);
      bus(1'b0, ADDR_CTRL, 32'h0, rd);
      cmp_word(rd, {rng[31:4], 4'hb} & 32'hf);
      run_path(1'b1, 1'b1);
      rng = xs(rng);
      bus(1'b1, ADDR_CTRL, {rng[31:4], 4'h9}, rd);
      run_path(1'b1, 1'b0);
      f_en <= 1'b0;
      repeat (700) @(posedge clk);
      cmp_word({30'h0, o_noe, o_poe}, 32'h0);
      bus(1'b0, ADDR_STATUS, 32'h0, rd);
      cmp_word(rd & 32'h1, 32'h0);
      host_mode <= 1'b0;
      e1_mode <= 1'b0;
      f_div <= 8'd54;
      run_path(1'b0, 1'b0);
      path_sel <= 1'b0;
      repeat (40) @(posedge clk);
      for (n = 0; n < 4000 && out_clk !== 1'b1; n++) @(posedge clk);
      if (n == 4000) error_cnt++;
      @(posedge clk);
      cmp_word({31'h0, out_clk}, 32'h0);
      wrap_up();
   end
endmodule
